// [design/event_counter.sv]
// Wrapping event counter driven by the selected event.
`timescale 1ns/10ps
`default_nettype none
module event_counter
  import home_agent_pkg::*;
#(
  parameter int CNT_W = 48
) (
  input wire logic clk,
  input wire logic rst_n,
  evt_if.cnt       bus
);
  // Whole state of the counter.
  typedef struct packed {
    logic [CNT_W-1:0] count;
  } cnt_state_t;
  cnt_state_t s_r;   // Registered state.
  cnt_state_t s_nxt; // Next state.

  // ----------------------------------------
  // Counting
  // ----------------------------------------
  // Clear wins over a coincident event, so software sees a clean start.
  always_comb begin
    s_nxt = s_r;
    if (bus.clr) begin
      s_nxt.count = '0;
    end else if (bus.en && bus.inc) begin
      s_nxt.count = s_r.count + 1'b1;
    end
  end

  // Registers the state.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.count = s_r.count;

  count_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    bus.en && bus.inc && !bus.clr |=> s_r.count == $past(s_r.count) + 1'b1)
    else $error("counter did not advance by one");
endmodule
`default_nettype wire

// [design/event_select.sv]
// Event selection by event code, unit mask and opcode match value.
`timescale 1ns/10ps
`default_nettype none
`include "home_agent_cfg.svh"
module event_select
  import home_agent_pkg::*;
(
  evt_if.sel bus
);
  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Unit mask bit that stands for a line state.
  function automatic logic [7:0] state_bit(input llc_state_t s);
    case (s)
      ST_M:    state_bit = `UM_ST_M;
      ST_E:    state_bit = `UM_ST_E;
      ST_S:    state_bit = `UM_ST_S;
      ST_F:    state_bit = `UM_ST_F;
      default: state_bit = `UM_ST_I;
    endcase
  endfunction

  // Unit mask bit that stands for a traffic source.
  function automatic logic [7:0] src_bit(input src_t s);
    case (s)
      SRC_IO_HUB: src_bit = `UM_IO_HUB;
      SRC_REMOTE: src_bit = `UM_REMOTE;
      default:    src_bit = `UM_LOCAL;
    endcase
  endfunction

  // Match value that selects a response opcode.
  function automatic logic [63:0] opc_code(input resp_op_t r);
    case (r)
      RSP_FWD_INV: opc_code = `MATCH_FWD_INV;
      RSP_FWD_SHR: opc_code = `MATCH_FWD_SHR;
      RSP_INV_WB:  opc_code = `MATCH_INV_WB;
      default:     opc_code = `MATCH_NONE;
    endcase
  endfunction

  // ----------------------------------------
  // Selection
  // ----------------------------------------
  // One increment per cycle at most, for the selected event only.
  always_comb begin
    case (bus.code)
      `EV_LLC_HIT:  bus.inc = bus.ev.llc_valid && bus.ev.llc_kind == LK_HIT;
      `EV_LLC_MISS: bus.inc = bus.ev.llc_valid && bus.ev.llc_kind == LK_MISS;
      `EV_LINES_ALLOC: bus.inc = bus.ev.llc_valid &&
        bus.ev.llc_kind == LK_ALLOC &&
        |(bus.umask & state_bit(bus.ev.llc_state));
      `EV_LINES_VICTIM: bus.inc = bus.ev.llc_valid &&
        bus.ev.llc_kind == LK_VICTIM &&
        |(bus.umask & state_bit(bus.ev.llc_state));
      // opcode match; a zero match value counts nothing.
      `EV_OPC_MATCH: bus.inc = bus.ev.resp != RSP_NONE &&
        bus.match != `MATCH_NONE &&
        bus.match == opc_code(bus.ev.resp) &&
        |(bus.umask & src_bit(bus.ev.resp_src));
      `EV_HOME_REQ: bus.inc =
        |(bus.umask & {4'h0, bus.ev.home_rwr, bus.ev.home_lwr,
                       bus.ev.home_rrd, bus.ev.home_lrd});
      `EV_NORMAL_RD: bus.inc = bus.ev.norm_rd;
      `EV_FULL_WR:   bus.inc = bus.ev.full_wr;
      // Unknown codes count nothing.
      default: bus.inc = 1'b0;
    endcase
  end

  zero_match_a: assert property (@(posedge bus.inc)
    bus.match != `MATCH_NONE || bus.code != `EV_OPC_MATCH)
    else $error("opcode event counted with zero match value");
endmodule
`default_nettype wire

// [design/home_agent_flow.sv]
// Home agent request, snoop and event counting flow of one socket.
//
// How it works
// - Miss address picks local or remote home.
// - Local home: memory request with the queries.
// - Remote home: request goes over the link.
// - Every miss queries all caching agents concurrently.
// - Remote cache answers first: local home request superseded.
// - Modified line answering a read of a local line: write back.
// - Local snoop hitting the cache: home told done.
// - Modified line, load snoop: writeback if local, forward line.
// - Modified read hit on a local line: writeback before fill.
// - Ownership read of modified line: no writeback.
// - Ownership snoop on shared line: invalidate, home supplies.
// - Opcode event 35H uses register 0x396.
// - Match values select forward and writeback opcodes.
// - Unit mask picks I/O hub, remote, local.
// - Hit and miss events at 08H, 09H.
// - Allocated and victimized lines by state.
// - Full write count adds one per cycle with any full line write.
// - Remote uncached and local cached writes counted.
// - Normal reads only reads; home reads include upgrades.
// - Bandwidth events at 20H, 2CH, 2FH.
// - Read snoop of modified local line writes back.
`timescale 1ns/10ps
`default_nettype none
`include "home_agent_cfg.svh"
module home_agent_flow
  import home_agent_pkg::*;
#(
  parameter int         ADDR_W     = 40,   // Physical address width.
  parameter int         HOME_BIT   = 39,   // Address bit naming the home.
  parameter logic       LOCAL_HOME = 1'b0, // Home bit value of this socket.
  parameter int         CNT_W      = 48    // Event counter width.
) (
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              MISS_VALID,
  input  wire logic [ADDR_W-1:0] MISS_ADDR,
  input  wire req_op_t           MISS_OP,
  output logic                   MISS_READY,
  output logic                   QUERY_ALL,
  output logic                   LINK_REQ,
  output logic                   MC_REQ,
  input  wire logic              RSP_VALID,
  input  wire logic              RSP_FROM_CACHE,
  input  wire logic              RSP_MOD,
  output logic                   HOME_DONE,
  output logic                   MC_WB,
  output logic                   LINK_FWD,
  output logic                   FILL_VALID,
  output logic                   FILL_FROM_HOME,
  input  wire logic              SNPIN_VALID,
  input  wire logic [ADDR_W-1:0] SNPIN_ADDR,
  input  wire logic              SNPIN_OWN,
  input  wire src_t              SNPIN_SRC,
  input  wire llc_state_t        LLC_STATE,
  output logic                   LLC_INV,
  output logic                   HOME_SUPPLY,
  input  wire logic              LLC_EVT_VALID,
  input  wire llc_kind_t         LLC_EVT_KIND,
  input  wire llc_state_t        LLC_EVT_STATE,
  input  wire logic              UC_WR_VALID,
  input  wire logic              UC_WR_REMOTE,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  input  wire logic [31:0]       REG_ADDR,
  input  wire logic [63:0]       REG_WDATA,
  output logic [63:0]            REG_RDATA,
  input  wire logic [7:0]        CNT_CODE,
  input  wire logic [7:0]        CNT_UMASK,
  input  wire logic              CNT_EN,
  input  wire logic              CNT_CLR,
  output logic [CNT_W-1:0]       CNT_VALUE
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  flow_state_t s_r;       // Registered state.
  flow_state_t s_nxt;     // Next state.
  logic        take;      // Miss accepted this cycle.
  logic        miss_loc;  // Miss line is homed here.
  logic        rsp_take;  // Answer taken while waiting.
  logic        snp_loc;   // Snooped line is homed here.
  logic        snp_held;  // Snooped line is present in the cache.
  logic        snp_mod;   // Snooped line is modified.
  logic        snp_shf;   // Snooped line is shared or forward.
  logic        reg_hit;   // Register access hits the match register.
  logic [CNT_W-1:0] cnt_q; // Counter value from the counter logic.

  evt_if #(.CNT_W(CNT_W)) ebus ();

  // ----------------------------------------
  // Home decode
  // ----------------------------------------
  // True when an address is homed on this socket's memory controller.
  function automatic logic is_local(input logic [ADDR_W-1:0] a);
    is_local = (a[HOME_BIT] == LOCAL_HOME);
  endfunction

  assign miss_loc = is_local(MISS_ADDR);
  assign snp_loc  = is_local(SNPIN_ADDR);
  // A miss is taken only while the ready flag stands.
  assign take     = MISS_VALID && s_r.miss_ready;
  assign rsp_take = RSP_VALID && s_r.st == FL_WAIT;
  assign snp_held = LLC_STATE != ST_I;
  assign snp_mod  = LLC_STATE == ST_M;
  assign snp_shf  = LLC_STATE == ST_S || LLC_STATE == ST_F;
  assign reg_hit  = REG_ADDR == `MATCH_REG_ADDR;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Miss flow, incoming snoops and register port share one process, so
  // strobes that both raise in one cycle merge into a single pulse.
  always_comb begin
    s_nxt = s_r;
    // Strobes last one cycle.
    s_nxt.query_all   = 1'b0;
    s_nxt.link_req    = 1'b0;
    s_nxt.mc_req      = 1'b0;
    s_nxt.home_done   = 1'b0;
    s_nxt.mc_wb       = 1'b0;
    s_nxt.link_fwd    = 1'b0;
    s_nxt.fill_valid  = 1'b0;
    s_nxt.fill_home   = 1'b0;
    s_nxt.llc_inv     = 1'b0;
    s_nxt.home_supply = 1'b0;
    s_nxt.ev          = '0;

    case (s_r.st)
      // Waits for a miss.
      FL_IDLE: begin
        if (take) begin
          s_nxt.op         = MISS_OP;
          s_nxt.home_local = miss_loc;
          s_nxt.query_all  = 1'b1;
          s_nxt.link_req   = 1'b1;
          s_nxt.mc_req     = miss_loc;
          s_nxt.ev.home_lrd = miss_loc;
          s_nxt.ev.norm_rd  = miss_loc && MISS_OP != OP_INV_EXCL;
          s_nxt.st          = FL_WAIT;
        end
      end
      // Waits for the first answer from a cache or a home.
      FL_WAIT: begin
        if (rsp_take) begin
          s_nxt.rsp_cache = RSP_FROM_CACHE;
          s_nxt.rsp_mod   = RSP_MOD;
          s_nxt.home_done = RSP_FROM_CACHE && s_r.home_local;
          // modified read of a local line goes to memory first
          if (RSP_MOD && s_r.op == OP_READ_DATA && s_r.home_local) begin
            s_nxt.st = FL_WB;
          end else begin
            s_nxt.st = FL_FILL;
          end
        end
      end
      // Writes the new line version to local memory.
      FL_WB: begin
        s_nxt.mc_wb       = 1'b1;
        s_nxt.ev.full_wr  = 1'b1;
        s_nxt.ev.home_lwr = 1'b1;
        s_nxt.st          = FL_FILL;
      end
      // Hands the line to the requester.
      FL_FILL: begin
        s_nxt.fill_valid = 1'b1;
        // modified reads come from home, ownership reads do not
        s_nxt.fill_home  = !s_r.rsp_cache ||
                           (s_r.rsp_mod && s_r.op == OP_READ_DATA);
        s_nxt.st         = FL_IDLE;
      end
      // Unreachable codes fall back to idle.
      default: begin
        s_nxt.st = FL_IDLE;
      end
    endcase
    // A new miss may be offered once the flow is idle again.
    s_nxt.miss_ready = s_nxt.st == FL_IDLE;

    // Incoming snoop, answered in the cycle after it arrives.
    if (SNPIN_VALID) begin
      s_nxt.ev.resp_src = SNPIN_SRC;
      // cache holds it, home is done
      if (snp_loc && snp_held) begin
        s_nxt.home_done = 1'b1;
      end
      if (snp_loc && SNPIN_SRC == SRC_REMOTE) begin
        s_nxt.ev.home_rrd = 1'b1;
      end
      if (snp_mod && !SNPIN_OWN) begin
        s_nxt.mc_wb       = snp_loc;
        s_nxt.ev.full_wr  = snp_loc;
        s_nxt.ev.home_lwr = snp_loc;
        s_nxt.link_fwd    = 1'b1;
        s_nxt.ev.resp     = RSP_INV_WB;
      end else if (snp_mod && SNPIN_OWN) begin
        s_nxt.link_fwd    = 1'b1;
        s_nxt.llc_inv     = 1'b1;
        s_nxt.ev.resp     = RSP_FWD_INV;
      end else if (snp_shf && SNPIN_OWN) begin
        s_nxt.llc_inv     = 1'b1;
        s_nxt.home_supply = 1'b1;
        s_nxt.ev.resp     = RSP_FWD_INV;
      end else if (snp_held && SNPIN_OWN) begin
        // Exclusive clean line moves to the requester.
        s_nxt.llc_inv     = 1'b1;
        s_nxt.link_fwd    = 1'b1;
        s_nxt.ev.resp     = RSP_FWD_INV;
      end else if (snp_held) begin
        // Clean line is shared with the requester.
        s_nxt.link_fwd    = 1'b1;
        s_nxt.ev.resp     = RSP_FWD_SHR;
      end
    end

    if (UC_WR_VALID) begin
      s_nxt.ev.full_wr  = 1'b1;
      s_nxt.ev.home_rwr = UC_WR_REMOTE;
    end

    s_nxt.ev.llc_valid = LLC_EVT_VALID;
    s_nxt.ev.llc_kind  = LLC_EVT_KIND;
    s_nxt.ev.llc_state = LLC_EVT_STATE;

    if (REG_WR && reg_hit) begin
      s_nxt.match = REG_WDATA;
    end
    if (REG_RD) begin
      // Other register numbers read as zero.
      s_nxt.rdata = reg_hit ? s_r.match : '0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Synchronous reset; the match register comes up matching nothing.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s_r       <= '0;
      s_r.match <= `MATCH_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Event counting
  // ----------------------------------------
  // Events reach the counter one cycle after their cause; the counter
  // therefore lags the flow outputs by one further cycle.
  assign ebus.code  = CNT_CODE;
  assign ebus.umask = CNT_UMASK;
  assign ebus.match = s_r.match;
  assign ebus.ev    = s_r.ev;
  assign ebus.en    = CNT_EN;
  assign ebus.clr   = CNT_CLR;
  assign cnt_q      = ebus.count;

  event_select u_sel (
    .bus (ebus.sel)
  );

  event_counter #(.CNT_W(CNT_W)) u_cnt (
    .clk   (CLK),
    .rst_n (RST_N),
    .bus   (ebus.cnt)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output is a flip-flop of the state or the counter.
  assign MISS_READY     = s_r.miss_ready;
  assign QUERY_ALL      = s_r.query_all;
  assign LINK_REQ       = s_r.link_req;
  assign MC_REQ         = s_r.mc_req;
  assign HOME_DONE      = s_r.home_done;
  assign MC_WB          = s_r.mc_wb;
  assign LINK_FWD       = s_r.link_fwd;
  assign FILL_VALID     = s_r.fill_valid;
  assign FILL_FROM_HOME = s_r.fill_home;
  assign LLC_INV        = s_r.llc_inv;
  assign HOME_SUPPLY    = s_r.home_supply;
  assign REG_RDATA      = s_r.rdata;
  assign CNT_VALUE      = cnt_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Writeback strobe followed by a fill sourced from home.
  sequence wb_then_fill;
    MC_WB ##1 (FILL_VALID && FILL_FROM_HOME);
  endsequence

  // Modified read answer for a local line.
  sequence dirty_read_rsp;
    rsp_take && RSP_MOD && s_r.op == OP_READ_DATA && s_r.home_local;
  endsequence

  miss_queries_a: assert property (take |=> QUERY_ALL && LINK_REQ)
    else $error("miss without queries");
  local_mc_a: assert property (take |=> MC_REQ == $past(miss_loc))
    else $error("memory request does not follow home");
  remote_link_a: assert property (
    take && !miss_loc |=> LINK_REQ && !MC_REQ)
    else $error("remote miss reached local memory");
  supersede_a: assert property (
    rsp_take && RSP_FROM_CACHE && s_r.home_local |=> HOME_DONE)
    else $error("home request not superseded");
  // The answer first moves the flow to the write state, so the writeback
  // strobe shows two cycles after the answer and the fill one cycle later.
  dirty_read_a: assert property (dirty_read_rsp |=> ##1 wb_then_fill)
    else $error("dirty read not written back before fill");
  own_no_wb_a: assert property (
    rsp_take && s_r.op == OP_READ_OWN && !SNPIN_VALID
    |=> !MC_WB ##1 (FILL_VALID && !MC_WB))
    else $error("ownership read wrote back");
  snoop_done_a: assert property (
    SNPIN_VALID && snp_loc && snp_held |=> HOME_DONE)
    else $error("home not told of cache hit");
  snoop_wb_a: assert property (
    SNPIN_VALID && snp_loc && snp_mod && !SNPIN_OWN |=> MC_WB && LINK_FWD)
    else $error("load snoop of dirty line not written back");
  shared_own_a: assert property (
    SNPIN_VALID && snp_shf && SNPIN_OWN
    |=> LLC_INV && HOME_SUPPLY && !LINK_FWD)
    else $error("shared line not invalidated");
  match_read_a: assert property (
    REG_WR && reg_hit ##1 REG_RD && reg_hit && !REG_WR
    |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("match register readback wrong");
endmodule
`default_nettype wire

// [include/evt_if.sv]
// Event and counter signals between the flow and its counter logic.
`timescale 1ns/10ps
`default_nettype none
interface evt_if #(parameter int CNT_W = 48);
  import home_agent_pkg::*;
  logic [7:0]       code;  // Selected event code.
  logic [7:0]       umask; // Selected unit mask.
  logic [63:0]      match; // Opcode match value.
  evt_t             ev;    // Events of this cycle.
  logic             en;    // Counter enable.
  logic             clr;   // Counter clear.
  logic             inc;   // Selected event occurred.
  logic [CNT_W-1:0] count; // Counter value.
  modport src (output code, umask, match, ev, en, clr, input count);
  modport sel (input code, umask, match, ev, output inc);
  modport cnt (input en, clr, inc, output count);
endinterface
`default_nettype wire

// [include/home_agent_cfg.svh]
// Constants for the home agent coherence flow and its event counter.
`ifndef HOME_AGENT_CFG_SVH
`define HOME_AGENT_CFG_SVH
// ----------------------------------------
// Opcode match register
// ----------------------------------------
// Register number of the opcode match register.
`define MATCH_REG_ADDR 32'h0000_0396
// Reset value, which matches no opcode.
`define MATCH_RESET 64'h0000_0000_0000_0000
// Match value that selects no opcode at all.
`define MATCH_NONE 64'h0000_0000_0000_0000
`define MATCH_FWD_INV 64'h4000_1900_0000_0000
`define MATCH_FWD_SHR 64'h4000_1a00_0000_0000
`define MATCH_INV_WB 64'h4000_1d00_0000_0000
// ----------------------------------------
// Event codes
// ----------------------------------------
`define EV_LLC_HIT 8'h08
`define EV_LLC_MISS 8'h09
`define EV_LINES_ALLOC 8'h0a
`define EV_LINES_VICTIM 8'h0b
`define EV_OPC_MATCH 8'h35
`define EV_HOME_REQ 8'h20
`define EV_NORMAL_RD 8'h2c
`define EV_FULL_WR 8'h2f
// ----------------------------------------
// Unit masks
// ----------------------------------------
// Traffic source for the opcode match event.
`define UM_IO_HUB 8'h01
`define UM_REMOTE 8'h02
`define UM_LOCAL 8'h04
// Home request kinds.
`define UM_HOME_LRD 8'h01
`define UM_HOME_RRD 8'h02
`define UM_HOME_LWR 8'h04
`define UM_HOME_RWR 8'h08
// Coherence state of allocated or victimized lines.
`define UM_ST_M 8'h01
`define UM_ST_E 8'h02
`define UM_ST_S 8'h04
`define UM_ST_I 8'h08
`define UM_ST_F 8'h10
`endif

// [include/home_agent_pkg.sv]
// Types shared by the home agent coherence flow modules.
package home_agent_pkg;
  // Request kinds issued after a cache miss.
  typedef enum logic [1:0] {OP_READ_DATA, OP_READ_OWN, OP_INV_EXCL} req_op_t;
  // Coherence state of a line in the last-level cache.
  typedef enum logic [2:0] {ST_I, ST_S, ST_E, ST_M, ST_F} llc_state_t;
  // Cache lookup and fill events.
  typedef enum logic [1:0] {LK_HIT, LK_MISS, LK_ALLOC, LK_VICTIM} llc_kind_t;
  // Traffic source of a snoop.
  typedef enum logic [1:0] {SRC_IO_HUB, SRC_REMOTE, SRC_LOCAL} src_t;
  // Snoop response opcodes.
  typedef enum logic [1:0] {RSP_NONE, RSP_FWD_INV, RSP_FWD_SHR,
                            RSP_INV_WB} resp_op_t;
  // Miss flow states.
  typedef enum logic [1:0] {FL_IDLE, FL_WAIT, FL_WB, FL_FILL} flow_t;
  // One cycle of countable events.
  typedef struct packed {
    logic       llc_valid;
    llc_kind_t  llc_kind;
    llc_state_t llc_state;
    resp_op_t   resp;
    src_t       resp_src;
    logic       home_lrd;
    logic       home_rrd;
    logic       home_lwr;
    logic       home_rwr;
    logic       norm_rd;
    logic       full_wr;
  } evt_t;
  // Whole state of the flow module.
  typedef struct packed {
    flow_t       st;
    req_op_t     op;
    logic        home_local;
    logic        rsp_cache;
    logic        rsp_mod;
    logic        miss_ready;
    logic        query_all;
    logic        link_req;
    logic        mc_req;
    logic        home_done;
    logic        mc_wb;
    logic        link_fwd;
    logic        fill_valid;
    logic        fill_home;
    logic        llc_inv;
    logic        home_supply;
    logic [63:0] match;
    logic [63:0] rdata;
    evt_t        ev;
  } flow_state_t;
endpackage

// [test/home_agent_flow_bench.sv]
// Bench for the home agent flow: misses, snoops, register and counter.
`timescale 1ns/10ps
`default_nettype none
`include "home_agent_cfg.svh"
module home_agent_flow_bench
  import home_agent_pkg::*;
;
  logic CLK, RST_N, MISS_VALID, MISS_READY, QUERY_ALL, LINK_REQ, MC_REQ;
  logic RSP_VALID, RSP_FROM_CACHE, RSP_MOD, HOME_DONE, MC_WB, LINK_FWD;
  logic FILL_VALID, FILL_FROM_HOME, SNPIN_VALID, SNPIN_OWN, LLC_INV;
  logic HOME_SUPPLY, LLC_EVT_VALID, UC_WR_VALID, UC_WR_REMOTE, REG_WR;
  logic REG_RD, CNT_EN, CNT_CLR, cache, mod;
  logic [39:0] MISS_ADDR, SNPIN_ADDR;
  logic [31:0] REG_ADDR;
  logic [63:0] REG_WDATA, REG_RDATA;
  logic [7:0]  CNT_CODE, CNT_UMASK, CNT_VALUE;
  logic [8:0]  seen;  // Sticky record of output pulses.
  logic [3:0]  lag;
  req_op_t     MISS_OP;
  src_t        SNPIN_SRC;
  llc_state_t  LLC_STATE, LLC_EVT_STATE;
  llc_kind_t   LLC_EVT_KIND;
  int          err_count, comparisons, cyc;
  home_agent_flow #(.CNT_W(8)) dut (.*);
  remote_agent peer (.clk(CLK), .rst_n(RST_N), .query(QUERY_ALL),
    .cache(cache), .mod(mod), .lag(lag), .rsp_valid(RSP_VALID),
    .rsp_cache(RSP_FROM_CACHE), .rsp_mod(RSP_MOD));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // Pulses last one cycle, so they are gathered; the cycle cap cuts hangs.
  always @(posedge CLK) begin
    seen <= seen | {QUERY_ALL, LINK_REQ, MC_REQ, MC_WB, HOME_DONE,
      FILL_VALID & FILL_FROM_HOME, LINK_FWD, LLC_INV, HOME_SUPPLY};
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_io(input logic wr, input logic [31:0] a);
    @(posedge CLK);
    REG_WR <= wr;
    REG_RD <= !wr;
    REG_ADDR <= a;
    REG_WDATA <= `MATCH_INV_WB;
    @(posedge CLK);
    REG_WR <= 1'b0;
    REG_RD <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic miss(input logic rem, input req_op_t op, input logic c,
                      input logic m, input logic [3:0] l, input logic [8:0] e);
    int n;
    @(posedge CLK);
    #1 seen = '0;
    @(posedge CLK);
    MISS_VALID <= 1'b1;
    MISS_ADDR <= {rem, 39'h0};
    MISS_OP <= op;
    {cache, mod, lag} <= {c, m, l};
    n = 0;
    do @(posedge CLK); while (MISS_READY !== 1'b1 && ++n < 50);
    MISS_VALID <= 1'b0;
    n = 0;
    do @(posedge CLK); while (FILL_VALID !== 1'b1 && ++n < 50);
    repeat (2) @(posedge CLK);
    chk(64'(seen), 64'(e));
  endtask
  task automatic snoop(input logic own, input llc_state_t s,
                       input logic [8:0] e);
    @(posedge CLK);
    #1 seen = '0;
    @(posedge CLK);
    SNPIN_VALID <= 1'b1;
    SNPIN_OWN <= own;
    LLC_STATE <= s;
    @(posedge CLK);
    SNPIN_VALID <= 1'b0;
    repeat (3) @(posedge CLK);
    chk(64'(seen), 64'(e));
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d bad=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {MISS_VALID, SNPIN_VALID, LLC_EVT_VALID, UC_WR_VALID, UC_WR_REMOTE} = '0;
    {REG_WR, REG_RD, CNT_EN, CNT_CLR, cache, mod, RST_N} = '0;
    {MISS_ADDR, SNPIN_ADDR, REG_ADDR, REG_WDATA, CNT_CODE, CNT_UMASK} = '0;
    {lag, seen, err_count, comparisons, cyc} = '0;
    MISS_OP = OP_READ_DATA;
    SNPIN_SRC = SRC_LOCAL;
    LLC_STATE = ST_I;
    LLC_EVT_STATE = ST_I;
    LLC_EVT_KIND = LK_HIT;
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    // Write, then read back in the very next cycle.
    @(posedge CLK);
    REG_ADDR <= `MATCH_REG_ADDR;
    REG_WDATA <= `MATCH_FWD_INV;
    REG_WR <= 1'b1;
    @(posedge CLK);
    {REG_WR, REG_RD} <= 2'b01;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(posedge CLK);
    chk(REG_RDATA, `MATCH_FWD_INV);
    reg_io(1'b1, `MATCH_REG_ADDR);
    reg_io(1'b0, `MATCH_REG_ADDR);
    chk(REG_RDATA, `MATCH_INV_WB);
    reg_io(1'b0, 32'h0000_0397);
    chk(REG_RDATA, 64'h0);
    $display("register test done");
    miss(1'b0, OP_READ_DATA, 1'b1, 1'b1, 4'h1, 9'h1f8);
    miss(1'b1, OP_READ_DATA, 1'b1, 1'b1, 4'h6, 9'h188);
    miss(1'b0, OP_READ_OWN, 1'b1, 1'b1, 4'h1, 9'h1d0);
    miss(1'b0, OP_READ_DATA, 1'b0, 1'b0, 4'h6, 9'h1c8);
    $display("miss test done");
    {CNT_CODE, CNT_UMASK, CNT_CLR, CNT_EN} <= {`EV_OPC_MATCH, `UM_LOCAL, 2'b11};
    @(posedge CLK);
    CNT_CLR <= 1'b0;
    snoop(1'b0, ST_M, 9'h034);
    chk(64'(CNT_VALUE), 64'h1);
    snoop(1'b1, ST_S, 9'h013);
    $display("snoop test done");
    {CNT_CODE, CNT_CLR, LLC_EVT_VALID} <= {`EV_LLC_MISS, 2'b11};
    LLC_EVT_KIND <= LK_MISS;
    @(posedge CLK);
    CNT_CLR <= 1'b0;
    LLC_EVT_KIND <= LK_HIT;
    @(posedge CLK);
    LLC_EVT_VALID <= 1'b0;
    repeat (3) @(posedge CLK);
    chk(64'(CNT_VALUE), 64'h1);
    {CNT_CODE, CNT_CLR, UC_WR_VALID} <= {`EV_FULL_WR, 2'b11};
    @(posedge CLK);
    {CNT_CLR, UC_WR_VALID} <= 2'b00;
    repeat (3) @(posedge CLK);
    chk(64'(CNT_VALUE), 64'h1);
    {CNT_CODE, CNT_UMASK, CNT_CLR} <= {`EV_HOME_REQ, `UM_HOME_LRD, 1'b1};
    @(posedge CLK);
    CNT_CLR <= 1'b0;
    miss(1'b0, OP_INV_EXCL, 1'b0, 1'b0, 4'h1, 9'h1c8);
    chk(64'(CNT_VALUE), 64'h1);
    $display("counter test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [test/remote_agent.sv]
// Model of the far caching agent that answers each miss after a lag.
`timescale 1ns/10ps
`default_nettype none
module remote_agent (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       query,
  input  wire logic       cache,
  input  wire logic       mod,
  input  wire logic [3:0] lag,
  output logic            rsp_valid,
  output logic            rsp_cache,
  output logic            rsp_mod
);
  logic [3:0] wait_r;  // Cycles left to the answer, zero when idle.
  // ----------------------------------------
  // Answer timing
  // ----------------------------------------
  // far cache answers
  always_ff @(posedge clk) begin
    if (!rst_n)
      wait_r <= 4'h0;
    else if (query)
      wait_r <= lag;
    else if (wait_r != 4'h0)
      wait_r <= wait_r - 4'h1;
  end
  // Qualifiers are inverted outside the answer, so stale ones never pass.
  assign rsp_valid = (wait_r == 4'h1);
  assign rsp_cache = rsp_valid ? cache : ~cache;
  assign rsp_mod   = rsp_valid ? mod : ~mod;
endmodule
`default_nettype wire
